/* File: tmc_defs.svh */
// Register offsets, field positions, reset values and timing counts for the timer channel
`ifndef TMC_DEFS_SVH
`define TMC_DEFS_SVH
`define TMC_OFF_STOP 8'h00
`define TMC_OFF_MASK 8'h04
`define TMC_OFF_FLAG 8'h08
`define TMC_OFF_PRIO0 8'h0c
`define TMC_OFF_PRIO1 8'h10
`define TMC_OFF_MODE 8'h14
`define TMC_OFF_DATA 8'h18
`define TMC_OFF_OMODE 8'h1c
`define TMC_OFF_OPOL 8'h20
`define TMC_OFF_OVAL 8'h24
`define TMC_OFF_OEN 8'h28
`define TMC_OFF_CKSEL 8'h2c
`define TMC_OFF_START 8'h30
`define TMC_OFF_STATUS 8'h34
`define TMC_OFF_COUNT 8'h38
`define TMC_CH_BIT 3
`define TMC_IRQ_BIT 5
`define TMC_MODE_CKS_HI 15
`define TMC_MODE_CKS_LO 14
`define TMC_MODE_CCS 12
`define TMC_MODE_SPLIT 11
`define TMC_MODE_STS_HI 10
`define TMC_MODE_STS_LO 8
`define TMC_MODE_CIS_HI 7
`define TMC_MODE_CIS_LO 6
`define TMC_MODE_MD_HI 3
`define TMC_MODE_MD_LO 1
`define TMC_MODE_RST 16'h0000
`define TMC_DATA_RST 16'h0000
`define TMC_MASK_RST 8'hff
`define TMC_CKSEL_RST 16'h0000
`define TMC_MD_INTERVAL 3'h0
`define TMC_STS_SOFT 3'h0
`define TMC_SYNC_STAGES 3
`endif

/* File: tmc_pkg.sv */
// Types shared by the timer channel modules
package tmc_pkg;
    typedef enum logic [1:0] {
        TMC_EDGE_FALL,
        TMC_EDGE_RISE,
        TMC_EDGE_BOTH_LO,
        TMC_EDGE_BOTH_HI
    } tmc_edge_e;
    typedef logic [15:0] tmc_word_t;
endpackage

/* File: tmc_tick_if.sv */
// Tick carrier between the prescaler and the channel core
`timescale 1ns/1ns
interface tmc_tick_if;
    logic [3:0] tick;
    modport src (output tick);
    modport dst (input tick);
endinterface

/* File: tmc_prescaler.sv */
// Free-running divider making the four prescaler tick enables
`timescale 1ns/1ns
module tmc_prescaler (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [15:0] i_sel,
    tmc_tick_if.src tick_bus
);
    logic [15:0] div_q;

    ////////////////////////////////////////////////////////////////////////
    // Divider counter, wraps freely
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    // One-cycle enable per output; a field of 0 ticks every cycle
    function automatic logic tick_of(input logic [3:0] f, input logic [15:0] c);
        logic [15:0] m;
        m = (16'h0001 << f) - 16'h0001;
        tick_of = ((c & m) == m);
    endfunction

    always_comb begin
        tick_bus.tick[0] = tick_of(i_sel[3:0], div_q); // [RQ16]
        tick_bus.tick[1] = tick_of(i_sel[7:4], div_q);
        tick_bus.tick[2] = tick_of(i_sel[11:8], div_q);
        tick_bus.tick[3] = tick_of(i_sel[15:12], div_q);
    end
endmodule

/* File: tmc_edge_sync.sv */
// Three-stage synchroniser and edge picker for the channel input pin
`timescale 1ns/1ns
module tmc_edge_sync (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_pin,
    input wire tmc_pkg::tmc_edge_e i_edge,
    output logic o_hit
);
    logic [2:0] sync_q;
    logic level_q;

    ////////////////////////////////////////////////////////////////////////
    // Stage one feeds stage two only; level updates when two and three agree
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sync_q <= 3'h0;
            level_q <= 1'b0;
        end else begin
            sync_q <= {sync_q[1:0], i_pin};
            if (sync_q[1] == sync_q[2]) begin
                level_q <= sync_q[2];
            end
        end
    end

    // Edge select; both-edge codes count either transition
    always_comb begin
        o_hit = 1'b0;
        if (sync_q[1] == sync_q[2] && sync_q[2] != level_q) begin
            unique case (i_edge)
                tmc_pkg::TMC_EDGE_FALL: o_hit = ~sync_q[2]; // [RQ9]
                tmc_pkg::TMC_EDGE_RISE: o_hit = sync_q[2];
                tmc_pkg::TMC_EDGE_BOTH_LO,
                tmc_pkg::TMC_EDGE_BOTH_HI: o_hit = 1'b1;
            endcase
        end
    end
endmodule

/* File: tmc_timer_channel.sv */
// Timer channel 3: AXI4-Lite registers, interval counter, output and interrupt
`timescale 1ns/1ns
`include "tmc_defs.svh"

// How it works
// RQ1: Writing 1 to stop bit clears running status and halts counting.
// RQ2: Mask bit 5 set blocks the count-end interrupt; clear allows it.
// RQ3: Flag bit 5 reads 1 once a request is pending; software clears it.
// RQ4: Priority bits at bit 5 of two registers select level; 00 highest.
// RQ5: Mode bits 15:14 choose which prescaler output feeds the channel.
// RQ6: Mode bit 12 chooses operating clock (0) or input pin edges (1).
// RQ7: Mode bit 11 splits the counter into two 8-bit timers; the code counts only the low byte, the high byte holds.
// RQ8: Trigger field 000 means only software start starts the channel.
// RQ9: Edge field bits 7:6 pick falling, rising or both pin edges.
// RQ10: Mode 000x is interval timer mode, counting down.
// RQ11: A 16-bit data register sets the interval the channel counts.
// RQ12: Output-mode bit 3 selects master (0) or slave (1) output.
// RQ13: Output-level bit 3 gives active-high (0) or inverted (1) output.
// RQ14: Output value bit 3 drives the output low (0) or high (1).
// RQ15: Output-enable bit 3 lets counting toggle the output bit.
// RQ16: Prescaler field n gives system clock divided by two to the n.
// RQ17: Load on start, decrement, reload and flag at zero: period n+1.
module tmc_timer_channel (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic [7:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic [7:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    input wire logic I_CHANNEL_INPUT_PIN,
    output logic O_CHANNEL_OUT,
    output logic O_COUNT_END_INTERRUPT,
    output logic [1:0] O_COUNT_END_LEVEL
);
    tmc_tick_if tick_bus ();

    logic [7:0] aw_addr_q;
    logic aw_have_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic w_have_q;
    logic wr_go;
    logic wr_ok;
    logic [31:0] rd_word;
    logic rd_ok;
    logic [7:0] mask_q;
    logic [7:0] flag_q;
    logic [7:0] prio0_q;
    logic [7:0] prio1_q;
    logic [15:0] mode_q;
    logic [15:0] data_q;
    logic [7:0] omode_q;
    logic [7:0] opol_q;
    logic [7:0] oval_q;
    logic [7:0] oen_q;
    logic [15:0] cksel_q;
    logic running_q;
    logic [15:0] count_q;
    logic load_q;
    logic pin_hit;
    logic op_tick;
    logic count_tick;
    logic count_end;
    logic stop_req;
    logic start_req;

    // Low byte helper for byte-strobed narrow registers
    function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
        merge8 = s[0] ? d[7:0] : old;
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // Operating-clock code to prescaler output; codes 01 and 10 cross over
    function automatic logic [1:0] tick_index(input logic [1:0] code);
        tick_index = {code[0], code[1]};
    endfunction

    // Interval mode ignores the lowest mode bit
    function automatic logic is_interval(input logic [15:0] mode);
        is_interval = mode[`TMC_MODE_MD_HI:`TMC_MODE_MD_LO] == `TMC_MD_INTERVAL;
    endfunction

    // Committed write with byte zero enabled to one offset
    function automatic logic low_write(input logic g, input logic [7:0] a, input logic [7:0] o, input logic [3:0] s);
        low_write = g && a == o && s[0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Prescaler and pin edge helpers
    tmc_prescaler u_prescaler (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_sel(cksel_q), // [RQ16]
        .tick_bus(tick_bus.src)
    );

    tmc_edge_sync u_edge_sync (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_pin(I_CHANNEL_INPUT_PIN),
        .i_edge(tmc_pkg::tmc_edge_e'(mode_q[`TMC_MODE_CIS_HI:`TMC_MODE_CIS_LO])), // [RQ9]
        .o_hit(pin_hit)
    );

    ////////////////////////////////////////////////////////////////////////
    // AXI write channels, taken in either order, one write at a time
    assign wr_go = aw_have_q && w_have_q && !O_BVALID;

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            O_AWREADY <= 1'b0;
        end else begin
            O_AWREADY <= !aw_have_q && !(I_AWVALID && O_AWREADY);
            if (I_AWVALID && O_AWREADY) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= I_AWADDR;
            end else if (wr_go) begin
                aw_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            w_have_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            O_WREADY <= 1'b0;
        end else begin
            O_WREADY <= !w_have_q && !(I_WVALID && O_WREADY);
            if (I_WVALID && O_WREADY) begin
                w_have_q <= 1'b1;
                w_data_q <= I_WDATA;
                w_strb_q <= I_WSTRB;
            end else if (wr_go) begin
                w_have_q <= 1'b0;
            end
        end
    end

    // Unmapped write offsets answer SLVERR
    always_comb begin
        unique case (aw_addr_q)
            `TMC_OFF_STOP, `TMC_OFF_MASK, `TMC_OFF_FLAG, `TMC_OFF_PRIO0, `TMC_OFF_PRIO1,
            `TMC_OFF_MODE, `TMC_OFF_DATA, `TMC_OFF_OMODE, `TMC_OFF_OPOL, `TMC_OFF_OVAL,
            `TMC_OFF_OEN, `TMC_OFF_CKSEL, `TMC_OFF_START: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_BVALID <= 1'b0;
            O_BRESP <= 2'h0;
        end else if (wr_go) begin
            O_BVALID <= 1'b1;
            O_BRESP <= wr_ok ? 2'h0 : 2'h2;
        end else if (I_BREADY) begin
            O_BVALID <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Plain configuration registers
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            mask_q <= `TMC_MASK_RST;
            prio0_q <= 8'hff;
            prio1_q <= 8'hff;
            mode_q <= `TMC_MODE_RST;
            data_q <= `TMC_DATA_RST;
            omode_q <= 8'h00;
            opol_q <= 8'h00;
            oen_q <= 8'h00;
            cksel_q <= `TMC_CKSEL_RST;
        end else if (wr_go) begin
            unique case (aw_addr_q)
                `TMC_OFF_MASK: mask_q <= merge8(mask_q, w_data_q, w_strb_q); // [RQ2]
                `TMC_OFF_PRIO0: prio0_q <= merge8(prio0_q, w_data_q, w_strb_q);
                `TMC_OFF_PRIO1: prio1_q <= merge8(prio1_q, w_data_q, w_strb_q);
                `TMC_OFF_MODE: mode_q <= merge16(mode_q, w_data_q, w_strb_q);
                `TMC_OFF_DATA: data_q <= merge16(data_q, w_data_q, w_strb_q); // [RQ11]
                `TMC_OFF_OMODE: omode_q <= merge8(omode_q, w_data_q, w_strb_q);
                `TMC_OFF_OPOL: opol_q <= merge8(opol_q, w_data_q, w_strb_q);
                `TMC_OFF_OEN: oen_q <= merge8(oen_q, w_data_q, w_strb_q);
                `TMC_OFF_CKSEL: cksel_q <= merge16(cksel_q, w_data_q, w_strb_q);
                default: ;
            endcase
        end
    end

    // Stop and start are write-one triggers; zeros do nothing
    assign stop_req = low_write(wr_go, aw_addr_q, `TMC_OFF_STOP, w_strb_q)
        && w_data_q[`TMC_CH_BIT]; // [RQ1]
    assign start_req = low_write(wr_go, aw_addr_q, `TMC_OFF_START, w_strb_q)
        && w_data_q[`TMC_CH_BIT]; // [RQ8]

    ////////////////////////////////////////////////////////////////////////
    // Counting clock choice
    // The code is not a plain index: 01 picks the third output, 10 the second
    always_comb begin
        op_tick = tick_bus.tick[tick_index(mode_q[`TMC_MODE_CKS_HI:`TMC_MODE_CKS_LO])]; // [RQ5]
        count_tick = mode_q[`TMC_MODE_CCS] ? pin_hit : op_tick; // [RQ6]
    end

    // Only interval mode counts; other mode codes hold the counter
    assign count_end = running_q && !load_q && count_tick
        && is_interval(mode_q)
        && (mode_q[`TMC_MODE_SPLIT] ? count_q[7:0] == 8'h00 : count_q == 16'h0000); // [RQ10]

    // Running status: stop wins over a same-cycle start
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            running_q <= 1'b0;
            load_q <= 1'b0;
        end else if (stop_req) begin
            running_q <= 1'b0; // [RQ1]
            load_q <= 1'b0;
        end else if (start_req) begin
            running_q <= 1'b1; // [RQ8]
            load_q <= 1'b1;
        end else begin
            load_q <= 1'b0;
        end
    end

    // Load on start, decrement per tick, reload at zero; split mode decrements and reloads the low byte only
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            count_q <= 16'h0000;
        end else if (load_q) begin
            count_q <= data_q; // [RQ17]
        end else if (running_q && count_tick
            && is_interval(mode_q)) begin
            if (mode_q[`TMC_MODE_SPLIT]) begin
                count_q[7:0] <= (count_q[7:0] == 8'h00) ? data_q[7:0] : count_q[7:0] - 8'h01; // [RQ7]
            end else begin
                count_q <= (count_q == 16'h0000) ? data_q : count_q - 16'h0001; // [RQ17]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request flag: set beats a write-one clear in the same cycle
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            flag_q <= 8'h00;
        end else begin
            if (low_write(wr_go, aw_addr_q, `TMC_OFF_FLAG, w_strb_q)) begin
                flag_q <= flag_q & ~w_data_q[7:0]; // [RQ3]
            end
            if (count_end) begin
                flag_q[`TMC_IRQ_BIT] <= 1'b1; // [RQ3]
            end
        end
    end

    // Output bit: written directly, toggled by count end only when enabled
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            oval_q <= 8'h00;
        end else if (low_write(wr_go, aw_addr_q, `TMC_OFF_OVAL, w_strb_q)) begin
            oval_q <= w_data_q[7:0]; // [RQ14]
        end else if (count_end && oen_q[`TMC_CH_BIT] && !omode_q[`TMC_CH_BIT]) begin
            oval_q[`TMC_CH_BIT] <= ~oval_q[`TMC_CH_BIT]; // [RQ15] [RQ12]
        end
    end

    // Registered pins; slave output mode just follows the output bit
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_CHANNEL_OUT <= 1'b0;
            O_COUNT_END_INTERRUPT <= 1'b0;
            O_COUNT_END_LEVEL <= 2'h3;
        end else begin
            O_CHANNEL_OUT <= oval_q[`TMC_CH_BIT] ^ opol_q[`TMC_CH_BIT]; // [RQ13]
            O_COUNT_END_INTERRUPT <= flag_q[`TMC_IRQ_BIT] & ~mask_q[`TMC_IRQ_BIT]; // [RQ2]
            O_COUNT_END_LEVEL <= {prio1_q[`TMC_IRQ_BIT], prio0_q[`TMC_IRQ_BIT]}; // [RQ4]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read decode; stop and start read as zero
    always_comb begin
        rd_ok = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (I_ARADDR)
            `TMC_OFF_STOP, `TMC_OFF_START: rd_word = 32'h0000_0000;
            `TMC_OFF_MASK: rd_word = {24'h000000, mask_q};
            `TMC_OFF_FLAG: rd_word = {24'h000000, flag_q};
            `TMC_OFF_PRIO0: rd_word = {24'h000000, prio0_q};
            `TMC_OFF_PRIO1: rd_word = {24'h000000, prio1_q};
            `TMC_OFF_MODE: rd_word = {16'h0000, mode_q};
            `TMC_OFF_DATA: rd_word = {16'h0000, data_q};
            `TMC_OFF_OMODE: rd_word = {24'h000000, omode_q};
            `TMC_OFF_OPOL: rd_word = {24'h000000, opol_q};
            `TMC_OFF_OVAL: rd_word = {24'h000000, oval_q};
            `TMC_OFF_OEN: rd_word = {24'h000000, oen_q};
            `TMC_OFF_CKSEL: rd_word = {16'h0000, cksel_q};
            `TMC_OFF_STATUS: rd_word = {28'h0000000, running_q, 3'h0};
            `TMC_OFF_COUNT: rd_word = {16'h0000, count_q};
            default: rd_ok = 1'b0;
        endcase
    end

    // Read address taken when no data is pending; data stands until RREADY
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_ARREADY <= 1'b0;
            O_RVALID <= 1'b0;
            O_RDATA <= 32'h0000_0000;
            O_RRESP <= 2'h0;
        end else begin
            O_ARREADY <= !O_RVALID && !(I_ARVALID && O_ARREADY);
            if (I_ARVALID && O_ARREADY) begin
                O_RVALID <= 1'b1;
                O_RDATA <= rd_word;
                O_RRESP <= rd_ok ? 2'h0 : 2'h2;
            end else if (I_RREADY) begin
                O_RVALID <= 1'b0;
            end
        end
    end
endmodule

/* File: tmc_timer_channel_asserts.sv */
// Port-level checks for the timer channel
`timescale 1ns/1ns
module tmc_timer_channel_asserts (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_AWVALID,
    input wire logic O_AWREADY,
    input wire logic I_WVALID,
    input wire logic O_WREADY,
    input wire logic [1:0] O_BRESP,
    input wire logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic I_ARVALID,
    input wire logic O_ARREADY,
    input wire logic [31:0] O_RDATA,
    input wire logic O_RVALID,
    input wire logic I_RREADY,
    input wire logic O_COUNT_END_INTERRUPT,
    input wire logic [1:0] O_COUNT_END_LEVEL
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_SYS_RST);
    ////////////////////////////////////////
    // Readies drop after a take, so one request is held at a time
    chk_aw_take_drop: assert property (I_AWVALID && O_AWREADY |=> !O_AWREADY)
        else $error("awready high after take");
    chk_w_take_drop: assert property (I_WVALID && O_WREADY |=> !O_WREADY)
        else $error("wready high after take");
    chk_ar_take_drop: assert property (I_ARVALID && O_ARREADY |=> !O_ARREADY)
        else $error("arready high after take");
    // Answers come in bounded time and stand until taken
    chk_read_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
        else $error("read answer late");
    chk_write_answer: assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##[1:4] O_BVALID)
        else $error("write answer late");
    chk_bresp_stands: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
        else $error("write response dropped");
    chk_rdata_stands: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
        else $error("read data dropped");
    // Interrupt and level only fall or move through a register write
    chk_irq_clear_path: assert property ($fell(O_COUNT_END_INTERRUPT) |-> ##[0:2] O_BVALID)
        else $error("interrupt fell without a write");
    chk_level_by_write: assert property ($changed(O_COUNT_END_LEVEL) |-> ##[0:2] O_BVALID)
        else $error("level moved without a write");
endmodule
bind tmc_timer_channel tmc_timer_channel_asserts u_asserts (.*);

/* File: tmc_timer_channel_bench.sv */
// Self-checking bench for the timer channel
`timescale 1ns/1ns
`include "tmc_defs.svh"
module tmc_timer_channel_bench;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic pin = 1'h1;
    logic awready, wready, bvalid, arready, rvalid, cout, irq;
    logic [1:0] bresp, rresp, level, r;
    logic [31:0] rdata, q;
    int errors = 0;
    int comparisons = 0;
    int p;
    tmc_timer_channel dut (.I_CLK(clk), .I_SYS_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
        .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wvalid), .O_WREADY(wready),
        .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
        .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp),
        .O_RVALID(rvalid), .I_RREADY(rready), .I_CHANNEL_INPUT_PIN(pin), .O_CHANNEL_OUT(cout),
        .O_COUNT_END_INTERRUPT(irq), .O_COUNT_END_LEVEL(level));
    // 50 MHz clock
    always #10 clk = ~clk;
    ////////////////////////////////////////
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, s, e);
        end
    endtask
    // One transfer; sampled at the falling edge so the take edge is never raced
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic t1, t2, v, t3;
        t3 = 1'h0;
        @(posedge clk);
        if (w) begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'h1;
            wvalid <= 1'h1;
        end else begin
            araddr <= a;
            arvalid <= 1'h1;
        end
        // Waits as long as the slave takes; only the hang guard ends it
        while (!t3) begin
            @(negedge clk);
            t1 = awvalid && awready || arvalid && arready;
            t2 = wvalid && wready;
            v = w ? bvalid : rvalid;
            t3 = v && (bready || rready);
            q = rdata;
            r = w ? bresp : rresp;
            @(posedge clk);
            if (t1) begin
                awvalid <= 1'h0;
                arvalid <= 1'h0;
            end
            if (t2) wvalid <= 1'h0;
            // Late ready keeps the response standing for a cycle
            if (t3) begin
                bready <= 1'h0;
                rready <= 1'h0;
            end else if (v) begin
                bready <= w;
                rready <= !w;
            end
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'h1, a, d);
        check(r, 2'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        check(r, 2'h0);
        check(q, e);
    endtask
    task automatic idle(input int c);
        repeat (c) @(negedge clk);
    endtask
    task automatic go;
        wr(`TMC_OFF_START, 32'h8);
    endtask
    task automatic halt;
        wr(`TMC_OFF_STOP, 32'h8);
    endtask
    // Cycles between two output toggles, bounded
    task automatic per;
        logic v;
        int n;
        n = 0;
        @(negedge clk);
        v = cout;
        while (cout === v && n < 600) begin
            @(negedge clk);
            n++;
        end
        v = cout;
        p = 0;
        while (cout === v && p < 600) begin
            @(negedge clk);
            p++;
        end
    endtask
    task automatic quiet(input int c, input logic e);
        logic v;
        @(negedge clk);
        v = cout;
        idle(c);
        check(32'(cout === v), 32'(e));
    endtask
    ////////////////////////////////////////
    task automatic t_reset;
        idle(1);
        check(level, 2'h3);
        check(irq, 1'h0);
        rd(`TMC_OFF_MASK, 32'hff);
        rd(`TMC_OFF_MODE, 32'h0);
        rd(`TMC_OFF_DATA, 32'h0);
    endtask
    task automatic t_regs;
        wr(`TMC_OFF_MODE, 32'hd9c1);
        rd(`TMC_OFF_MODE, 32'hd9c1);
        wr(`TMC_OFF_DATA, 32'hea5f);
        rd(`TMC_OFF_DATA, 32'hea5f);
        // Unmapped place answers with an error and no data
        bus(1'h0, 8'h3c, 32'h0);
        check(r, 2'h2);
        check(q, 32'h0);
        bus(1'h1, 8'h40, 32'h5);
        check(r, 2'h2);
    endtask
    task automatic t_prio;
        for (int i = 0; i < 4; i++) begin
            wr(`TMC_OFF_PRIO0, 32'(i % 2) << 5);
            wr(`TMC_OFF_PRIO1, 32'(i / 2) << 5);
            idle(2);
            check(level, 32'(i));
        end
    endtask
    task automatic t_interval;
        wr(`TMC_OFF_MODE, 32'h0);
        wr(`TMC_OFF_CKSEL, 32'h0);
        wr(`TMC_OFF_DATA, 32'h3);
        wr(`TMC_OFF_OEN, 32'h8);
        wr(`TMC_OFF_MASK, 32'h0);
        go();
        per();
        check(p, 4);
        check(irq, 1'h1);
        wr(`TMC_OFF_MASK, 32'h20);
        idle(2);
        check(irq, 1'h0);
        rd(`TMC_OFF_STATUS, 32'h8);
        halt();
        rd(`TMC_OFF_STATUS, 32'h0);
        quiet(40, 1'h1);
        wr(`TMC_OFF_FLAG, 32'h20);
        rd(`TMC_OFF_FLAG, 32'h0);
        wr(`TMC_OFF_MASK, 32'h0);
        idle(2);
        check(irq, 1'h0);
    endtask
    // Each clock-select code against the divider field it maps to; codes 01 and 10 cross over
    task automatic t_clocks;
        int e[4];
        e = '{16, 8, 4, 32};
        wr(`TMC_OFF_CKSEL, 32'h3102);
        for (int i = 0; i < 4; i++) begin
            halt();
            wr(`TMC_OFF_MODE, 32'(i) << 14);
            go();
            per();
            check(p, e[i]);
        end
        wr(`TMC_OFF_CKSEL, 32'h0);
    endtask
    task automatic t_split;
        halt();
        wr(`TMC_OFF_DATA, 32'h0103);
        wr(`TMC_OFF_MODE, 32'h0800);
        go();
        per();
        check(p, 4);
    endtask
    task automatic t_mode;
        halt();
        wr(`TMC_OFF_DATA, 32'h3);
        wr(`TMC_OFF_MODE, 32'h4);
        go();
        quiet(50, 1'h1);
        halt();
        wr(`TMC_OFF_MODE, 32'h1);
        go();
        per();
        check(p, 4);
    endtask
    task automatic t_out;
        wr(`TMC_OFF_OMODE, 32'h8);
        quiet(40, 1'h1);
        wr(`TMC_OFF_OMODE, 32'h0);
        wr(`TMC_OFF_OEN, 32'h0);
        quiet(40, 1'h1);
        wr(`TMC_OFF_OEN, 32'h8);
        // Toggles every 4 cycles: a window of 36 holds an odd count of them
        quiet(36, 1'h0);
        halt();
        wr(`TMC_OFF_OEN, 32'h0);
        wr(`TMC_OFF_OVAL, 32'h0);
        idle(2);
        check(cout, 1'h0);
        wr(`TMC_OFF_OVAL, 32'h8);
        idle(2);
        check(cout, 1'h1);
        wr(`TMC_OFF_OPOL, 32'h8);
        idle(2);
        check(cout, 1'h0);
        wr(`TMC_OFF_OVAL, 32'h0);
        idle(2);
        check(cout, 1'h1);
        wr(`TMC_OFF_OPOL, 32'h0);
    endtask
    // Pin edges count only with the edge that the field picks
    task automatic t_pin;
        wr(`TMC_OFF_DATA, 32'h0);
        wr(`TMC_OFF_OEN, 32'h8);
        for (int e = 0; e < 3; e++) begin
            halt();
            wr(`TMC_OFF_MODE, 32'h1000 | (32'(e) << 6));
            go();
            @(posedge clk);
            pin <= 1'h0;
            quiet(10, e == 1);
            @(posedge clk);
            pin <= 1'h1;
            quiet(10, e == 0);
        end
    endtask
    ////////////////////////////////////////
    task automatic results;
        if (errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Main sequence after a two-cycle reset
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        t_reset();
        t_regs();
        t_prio();
        t_interval();
        t_clocks();
        t_split();
        t_mode();
        t_out();
        t_pin();
        results();
    end
    // Hang guard, well beyond the expected run
    initial begin
        #400000;
        errors++;
        results();
    end
endmodule
